/* File: rtl/tfc_pkg.sv */
package tfc_pkg;
	// address widths of the two cores
	localparam int TFC_MAIN_AW = 23;
	localparam int TFC_COP_AW  = 16;
	localparam int TFC_ADDR_W  = 23;
	// entry word: info byte above the address
	localparam int TFC_INFO_W  = 8;
	localparam int TFC_ENTRY_W = TFC_INFO_W + TFC_ADDR_W;
	// info byte fields
	localparam int TFC_INFO_DEST_BIT = 0;
	localparam int TFC_INFO_COP_BIT  = 1;
	localparam int TFC_INFO_VEC_BIT  = 2;
	// pending queue depth for coinciding events
	localparam int TFC_QDEPTH  = 4;
	localparam int TFC_QPTR_W  = 2;
	localparam logic [TFC_INFO_W-1:0] TFC_INFO_RESET = 8'h00;

	// main processor retired instruction classes
	typedef enum logic [3:0] {
		TFC_MC_OTHER                        = 4'h0,
		TFC_MC_RETURN_FROM_INTERRUPT_INSTR  = 4'h1,
		TFC_MC_RTS                          = 4'h2,
		TFC_MC_RTC                          = 4'h3,
		TFC_MC_JUMP_INSTR_IDX               = 4'h4,
		TFC_MC_JUMP_TO_SUBROUTINE_INSTR_IDX = 4'h5,
		TFC_MC_CALL_IDX                     = 4'h6,
		TFC_MC_JUMP_INSTR                   = 4'h7,
		TFC_MC_JUMP_TO_SUBROUTINE_INSTR     = 4'h8,
		TFC_MC_CALL                         = 4'h9,
		TFC_MC_LONG_BRANCH_ALWAYS_INSTR     = 4'hA,
		TFC_MC_BRANCH_ALWAYS_INSTR          = 4'hB,
		TFC_MC_BRANCH_TO_SUBROUTINE_INSTR   = 4'hC,
		TFC_MC_ENTER_BACKGROUND_INSTR       = 4'hD,
		TFC_MC_COND_BRANCH                  = 4'hE
	} tfc_main_class_t;

	// coprocessor retired instruction classes
	typedef enum logic [1:0] {
		TFC_CC_OTHER     = 2'h0,
		TFC_CC_COND_BR   = 2'h1,
		TFC_CC_JUMP_AND_LINK_INSTR_IDX = 2'h2
	} tfc_cop_class_t;

	// vector kinds taken by the main processor
	typedef enum logic [1:0] {
		TFC_VK_NORMAL   = 2'h0,
		TFC_VK_SOFTWARE_INTERRUPT    = 2'h1,
		TFC_VK_BACKGROUND_DEBUG_MODE = 2'h2
	} tfc_vec_kind_t;

	// writer state, one-hot
	typedef enum logic [1:0] {
		TFC_W_IDLE = 2'b01,
		TFC_W_BUSY = 2'b10
	} tfc_wstate_t;
endpackage

/* File: rtl/tfc_event_queue.sv */
`timescale 1ns/1ps
module tfc_event_queue
	import tfc_pkg::*;
(
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	// up to three entries pushed per cycle, slot 0 oldest
	input  wire logic [2:0]             push_valid,
	input  wire logic [TFC_ENTRY_W-1:0] push_entry0,
	input  wire logic [TFC_ENTRY_W-1:0] push_entry1,
	input  wire logic [TFC_ENTRY_W-1:0] push_entry2,
	// drain side
	output logic                        pop_valid,
	output logic [TFC_ENTRY_W-1:0]      pop_entry,
	input  wire logic                   pop_ready,
	output logic                        overflow
);
	logic [TFC_ENTRY_W-1:0] mem_reg [TFC_QDEPTH];
	logic [TFC_QPTR_W-1:0]  rd_reg;
	logic [TFC_QPTR_W:0]    cnt_reg;
	logic [TFC_QPTR_W:0]    n_acc;
	logic [TFC_QPTR_W:0]    fill;
	logic [2:0]             acc;
	logic                   lost;
	logic                   do_pop;

	assign do_pop = pop_valid && pop_ready;

	// slots beyond the free room are dropped and flagged, never overwrite a held entry
	always_comb
	begin
		fill  = cnt_reg - {2'b00, do_pop};
		n_acc = '0;
		acc   = 3'b000;
		lost  = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			if (push_valid[i])
			begin
				if (fill + n_acc < 3'(TFC_QDEPTH))
				begin
					acc[i] = 1'b1;
					n_acc  = n_acc + 3'd1;
				end
				else
					lost = 1'b1;
			end
		end
	end

	// storage writes keep arrival order, slot by slot
	always_ff @(posedge mclk)
	begin
		logic [TFC_QPTR_W-1:0] wp;
		wp = rd_reg + cnt_reg[TFC_QPTR_W-1:0];
		for (int i = 0; i < 3; i++)
		begin
			if (acc[i])
			begin
				if (i == 0)
					mem_reg[wp] <= push_entry0;
				else if (i == 1)
					mem_reg[wp] <= push_entry1;
				else
					mem_reg[wp] <= push_entry2;
				wp = wp + 2'd1;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (do_pop)
				rd_reg <= rd_reg + 2'd1;
			cnt_reg <= fill + n_acc;
		end
	end

	// sticky loss flag, cleared only by reset
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			overflow <= 1'b0;
		else if (lost)
			overflow <= 1'b1;
	end

	assign pop_valid = (cnt_reg != '0);
	assign pop_entry = mem_reg[rd_reg];
endmodule

/* File: rtl/tfc_capture.sv */
`timescale 1ns/1ps
module tfc_capture
	import tfc_pkg::*;
(
	// clock and reset
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	// main processor retire tap
	input  wire logic                      main_retire,
	input  wire tfc_pkg::tfc_main_class_t  main_class,
	input  wire logic                      main_taken,
	input  wire logic [TFC_MAIN_AW-1:0]    main_src_addr,
	input  wire logic [TFC_MAIN_AW-1:0]    main_dest_addr,
	// main processor vector fetch tap
	input  wire logic                      main_vector,
	input  wire tfc_pkg::tfc_vec_kind_t    main_vec_kind,
	input  wire logic [TFC_MAIN_AW-1:0]    main_vec_addr,
	// coprocessor retire tap
	input  wire logic                      cop_retire,
	input  wire tfc_pkg::tfc_cop_class_t   cop_class,
	input  wire logic                      cop_taken,
	input  wire logic                      cop_thread_start,
	input  wire logic [TFC_COP_AW-1:0]     cop_src_addr,
	input  wire logic [TFC_COP_AW-1:0]     cop_dest_addr,
	// trace buffer write port
	output logic                           trace_wr,
	output logic [TFC_ENTRY_W-1:0]         trace_entry,
	input  wire logic                      trace_ready,
	output logic                           trace_overflow
);
	import tfc_pkg::*;

	tfc_wstate_t            state_reg;
	logic [2:0]             push_valid;
	logic [TFC_ENTRY_W-1:0] e_main;
	logic [TFC_ENTRY_W-1:0] e_vec;
	logic [TFC_ENTRY_W-1:0] e_cop;
	logic                   q_valid;
	logic [TFC_ENTRY_W-1:0] q_entry;
	logic                   main_hit;
	logic                   main_dest;
	logic                   vec_hit;
	logic                   cop_hit;
	logic                   cop_dest;
	logic                   q_ready;
	logic [TFC_MAIN_AW-1:0] main_addr;
	logic [TFC_COP_AW-1:0]  cop_addr;
	logic [TFC_ADDR_W-1:0]  cop_addr_ext;
	logic [TFC_INFO_W-1:0]  main_info;
	logic [TFC_INFO_W-1:0]  vec_info;
	logic [TFC_INFO_W-1:0]  cop_info;

	// info byte builder
	function automatic logic [TFC_INFO_W-1:0] info_byte(
		input logic dest,
		input logic cop,
		input logic vec
	);
		logic [TFC_INFO_W-1:0] b;
		b = TFC_INFO_RESET;
		b[TFC_INFO_DEST_BIT] = dest;
		b[TFC_INFO_COP_BIT]  = cop;
		b[TFC_INFO_VEC_BIT]  = vec;
		return b;
	endfunction

	// entry word: info byte above the address
	function automatic logic [TFC_ENTRY_W-1:0] make_entry(
		input logic [TFC_INFO_W-1:0] info,
		input logic [TFC_ADDR_W-1:0] addr
	);
		return {info, addr};
	endfunction

	// main processor classification
	always_comb
	begin
		main_hit  = 1'b0;
		main_dest = 1'b1;
		unique case (main_class)
			TFC_MC_RETURN_FROM_INTERRUPT_INSTR,
			TFC_MC_RTS,
			TFC_MC_RTC:
				main_hit = 1'b1;
			TFC_MC_JUMP_INSTR_IDX,
			TFC_MC_JUMP_TO_SUBROUTINE_INSTR_IDX,
			TFC_MC_CALL_IDX:
				main_hit = 1'b1;
			TFC_MC_COND_BRANCH:
			begin
				main_hit  = main_taken;
				main_dest = 1'b0;
			end
			TFC_MC_JUMP_INSTR,
			TFC_MC_JUMP_TO_SUBROUTINE_INSTR,
			TFC_MC_CALL,
			TFC_MC_LONG_BRANCH_ALWAYS_INSTR,
			TFC_MC_BRANCH_ALWAYS_INSTR,
			TFC_MC_BRANCH_TO_SUBROUTINE_INSTR,
			TFC_MC_ENTER_BACKGROUND_INSTR,
			TFC_MC_OTHER:
				main_hit = 1'b0;
			default:
				main_hit = 1'b0;
		endcase
		main_hit = main_hit && main_retire;
	end

	// vector filter: only ordinary interrupt vectors make an entry
	always_comb
	begin
		vec_hit = 1'b0;
		unique case (main_vec_kind)
			TFC_VK_NORMAL:
				vec_hit = main_vector;
			TFC_VK_SOFTWARE_INTERRUPT,
			TFC_VK_BACKGROUND_DEBUG_MODE:
				vec_hit = 1'b0;
			default:
				vec_hit = 1'b0;
		endcase
	end

	// coprocessor classification
	always_comb
	begin
		cop_hit  = 1'b0;
		cop_dest = 1'b1;
		if (cop_retire)
		begin
			unique case (cop_class)
				TFC_CC_COND_BR:
				begin
					cop_hit  = cop_taken;
					cop_dest = 1'b0;
				end
				TFC_CC_JUMP_AND_LINK_INSTR_IDX:
					cop_hit = 1'b1;
				TFC_CC_OTHER:
					cop_hit = 1'b0;
				default:
					cop_hit = 1'b0;
			endcase
		end
		if (cop_thread_start)
		begin
			cop_hit  = 1'b1;
			cop_dest = 1'b1;
		end
	end

	// address each entry carries
	always_comb
	begin
		main_addr = main_src_addr;
		if (main_dest)
			main_addr = main_dest_addr;
		cop_addr = cop_src_addr;
		if (cop_thread_start || cop_dest)
			cop_addr = cop_dest_addr;
	end

	assign main_info    = info_byte(main_dest, 1'b0, 1'b0);
	assign vec_info     = info_byte(1'b1, 1'b0, 1'b1);
	assign cop_info     = info_byte(cop_dest, 1'b1, 1'b0);
	// coprocessor address zero-extended to the main core width
	assign cop_addr_ext = {{(TFC_ADDR_W-TFC_COP_AW){1'b0}}, cop_addr};
	assign e_main       = make_entry(main_info, main_addr);
	assign e_vec        = make_entry(vec_info, main_vec_addr);
	assign e_cop        = make_entry(cop_info, cop_addr_ext);

	// completed flow entry goes ahead of the coinciding vector
	assign push_valid = {cop_hit, vec_hit, main_hit};
	assign q_ready    = (state_reg == TFC_W_IDLE);

	tfc_event_queue u_queue (
		.mclk        (mclk),
		.resetn      (resetn),
		.push_valid  (push_valid),
		.push_entry0 (e_main),
		.push_entry1 (e_vec),
		.push_entry2 (e_cop),
		.pop_valid   (q_valid),
		.pop_entry   (q_entry),
		.pop_ready   (q_ready),
		.overflow    (trace_overflow)
	);

	// writer: one registered write per entry, in queue order
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg   <= TFC_W_IDLE;
			trace_entry <= '0;
		end
		else
		begin
			unique case (state_reg)
				TFC_W_IDLE:
					if (q_valid)
					begin
						trace_entry <= q_entry;
						state_reg   <= TFC_W_BUSY;
					end
				TFC_W_BUSY:
					if (trace_ready)
						state_reg <= TFC_W_IDLE;
				default:
					state_reg <= TFC_W_IDLE;
			endcase
		end
	end

	assign trace_wr = (state_reg == TFC_W_BUSY);
endmodule

/* File: sim/tfc_capture_properties.sv */
`timescale 1ns/1ps
module tfc_capture_checker
	import tfc_pkg::*;
(
	input wire logic			mclk,
	input wire logic			resetn,
	input wire logic			main_retire,
	input wire logic			main_vector,
	input wire logic			cop_retire,
	input wire logic			cop_thread_start,
	input wire logic			trace_wr,
	input wire logic [TFC_ENTRY_W-1:0]	trace_entry,
	input wire logic			trace_ready,
	input wire logic			trace_overflow
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	wire ev = main_retire | main_vector | cop_retire | cop_thread_start;
	AST_HOLD: assert property (
		trace_wr && !trace_ready |=> trace_wr && $stable(trace_entry))
		else $error("entry changed before accept");
	AST_GAP: assert property (
		trace_wr && trace_ready |=> !trace_wr)
		else $error("no idle cycle after write");
	AST_INFO_ZERO: assert property (
		trace_wr |-> trace_entry[30:26] == 5'h00)
		else $error("unused info bits set");
	AST_COP_WIDTH: assert property (
		trace_wr && trace_entry[24] |-> trace_entry[22:16] == 7'h00)
		else $error("coprocessor address wider than 16 bits");
	AST_VEC_DEST: assert property (
		trace_wr && trace_entry[25] |-> trace_entry[24:23] == 2'h1)
		else $error("vector entry not a main destination");
	AST_OVF_STICKY: assert property (
		$rose(trace_overflow) |=> trace_overflow [*3])
		else $error("overflow flag cleared");
	AST_FIRST: assert property (
		$rose(resetn) |-> !trace_wr ##1 !trace_wr)
		else $error("write too early after reset");
	AST_QUIET: assert property (
		(!trace_wr && !ev) [*3] |=> !trace_wr)
		else $error("write without an event");
	cover property (trace_wr && !trace_ready);
	cover property ($rose(trace_overflow));
	cover property (trace_wr && trace_ready && trace_entry[25]);
endmodule

/* File: sim/tfc_buf_model.sv */
`timescale 1ns/1ps
module tfc_buf_model
(
	input wire logic	mclk,
	input wire logic	resetn,
	input wire logic	stall,
	input wire logic	trace_wr,
	input wire logic [30:0]	trace_entry,
	output logic		trace_ready
);
	logic [30:0] got[$];
	initial trace_ready = 1'b0;
	// ready follows the stall request one edge later, never racing the bench
	always @(posedge mclk)
		trace_ready <= resetn && !stall;
	always @(posedge mclk)
		if (trace_wr && trace_ready)
			got.push_back(trace_entry);
endmodule

/* File: sim/trace_flow_change_capture_bench.sv */
`timescale 1ns/1ps
module trace_flow_change_capture_bench;
	import tfc_pkg::*;
	logic mclk, resetn, stall, m_r, m_t, m_v, c_r, c_t, c_s, wr, rdy, ovf;
	tfc_main_class_t mc;
	tfc_vec_kind_t vk;
	tfc_cop_class_t cc;
	logic [22:0] ms, md, va;
	logic [15:0] cs, cd;
	logic [30:0] ent;
	int errors, samples_checked;
	// row: kind[8:7] code[6:3] taken[2] expect[1] dest[0]
	logic [8:0] rows[24] = '{9'h00F, 9'h017, 9'h01F, 9'h027, 9'h02F, 9'h037, 9'h03C,
		9'h044, 9'h04C, 9'h054, 9'h05C, 9'h064, 9'h06C, 9'h004, 9'h076, 9'h070,
		9'h083, 9'h088, 9'h090, 9'h10E, 9'h108, 9'h117, 9'h104, 9'h187};
	tfc_capture tfc_capture_i(.mclk(mclk), .resetn(resetn), .main_retire(m_r),
		.main_class(mc), .main_taken(m_t), .main_src_addr(ms), .main_dest_addr(md),
		.main_vector(m_v), .main_vec_kind(vk), .main_vec_addr(va), .cop_retire(c_r),
		.cop_class(cc), .cop_taken(c_t), .cop_thread_start(c_s), .cop_src_addr(cs),
		.cop_dest_addr(cd), .trace_wr(wr), .trace_entry(ent), .trace_ready(rdy),
		.trace_overflow(ovf));
	tfc_buf_model tfc_buf_model_i(.mclk(mclk), .resetn(resetn), .stall(stall),
		.trace_wr(wr), .trace_entry(ent), .trace_ready(rdy));
	task end_sim;
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string n, input logic [30:0] e, input logic [30:0] g);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	function logic [30:0] ex(input logic [1:0] k, input logic d);
		logic [22:0] a;
		a = k == 2'h1 ? va : k[1] ? {7'h00, d ? cd : cs} : d ? md : ms;
		ex = {5'h00, k == 2'h1, k[1], d, a};
	endfunction
	// main flow, vector and coprocessor jump in one cycle
	task all3(input logic on);
		m_r = on;
		mc = TFC_MC_JUMP_INSTR_IDX;
		m_v = on;
		vk = TFC_VK_NORMAL;
		c_r = on;
		cc = TFC_CC_JUMP_AND_LINK_INSTR_IDX;
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		#50000;
		errors++;
		end_sim();
	end
	initial
	begin
		{resetn, stall, m_t, c_t, c_s, errors, samples_checked} = '0;
		{ms, md, va, cs, cd} = {23'h123456, 23'h7ABCDE, 23'h7FFFF2, 16'hC0DE, 16'hBEEF};
		all3(1'b0);
		repeat (12) @(negedge mclk);
		resetn = 1'b1;
		foreach (rows[i])
		begin
			tfc_buf_model_i.got.delete();
			m_r = rows[i][8:7] == 2'h0;
			mc = tfc_main_class_t'(rows[i][6:3]);
			m_v = rows[i][8:7] == 2'h1;
			vk = tfc_vec_kind_t'(rows[i][4:3]);
			c_r = rows[i][8:7] == 2'h2;
			cc = tfc_cop_class_t'(rows[i][4:3]);
			c_s = rows[i][8:7] == 2'h3;
			{m_t, c_t} = {2{rows[i][2]}};
			@(negedge mclk);
			{m_r, m_v, c_r, c_s} = 4'h0;
			repeat (6) @(negedge mclk);
			chk("count", 31'(rows[i][1]),
				31'(tfc_buf_model_i.got.size()));
			if (rows[i][1])
				chk("entry", ex(rows[i][8:7], rows[i][0]),
					tfc_buf_model_i.got[0]);
		end
		tfc_buf_model_i.got.delete();
		stall = 1'b1;
		all3(1'b1);
		@(negedge mclk);
		all3(1'b0);
		m_r = 1'b1;
		mc = TFC_MC_RETURN_FROM_INTERRUPT_INSTR;
		md = 23'h000042;
		@(negedge mclk);
		m_r = 1'b0;
		repeat (6) @(negedge mclk);
		chk("stalled", {8'h01, 23'h7ABCDE}, wr ? ent : 31'h0);
		stall = 1'b0;
		repeat (12) @(negedge mclk);
		md = 23'h7ABCDE;
		chk("n", 31'h4, 31'(tfc_buf_model_i.got.size()));
		foreach (tfc_buf_model_i.got[i])
			chk("order", i == 3 ? {8'h01, 23'h000042} : ex(2'(i), 1'b1),
				tfc_buf_model_i.got[i]);
		stall = 1'b1;
		all3(1'b1);
		repeat (3) @(negedge mclk);
		all3(1'b0);
		repeat (2) @(negedge mclk);
		chk("overflow", 31'h1, 31'(ovf));
		resetn = 1'b0;
		stall = 1'b0;
		repeat (2) @(negedge mclk);
		chk("reset", 31'h0, {wr, ovf} === 2'b00 ? ent : 31'h1);
		resetn = 1'b1;
		repeat (4) @(negedge mclk);
		end_sim();
	end
endmodule
bind tfc_capture tfc_capture_checker tfc_capture_checker_i(.mclk(mclk), .resetn(resetn),
	.main_retire(main_retire), .main_vector(main_vector), .cop_retire(cop_retire),
	.cop_thread_start(cop_thread_start), .trace_wr(trace_wr), .trace_entry(trace_entry),
	.trace_ready(trace_ready), .trace_overflow(trace_overflow));
